// file: logic/aboc_pkg.sv
package aboc_pkg;
   localparam int          ADDR_W           = 16;
   localparam int          DATA_W           = 32;
   localparam int          COUNT_W          = 7;
   localparam int          MEM_WORDS        = 512;
   localparam int          KEY_WORDS        = 8;
   // memory windows: offsets 0x0000..0x07ff above each base
   localparam logic [15:0] PLAIN_BASE       = 16'h0000;
   localparam logic [15:0] CIPHER_BASE      = 16'h2000;
   localparam logic [15:0] FILL_SPAN_LAST   = 16'h07ff;
   localparam int          MEM_SEL_LSB      = 11;
   localparam int          WORD_LSB         = 2;
   // control registers
   localparam logic [15:0] ENC_CNT_OFS      = 16'h4000;
   localparam logic [15:0] DEC_CNT_OFS      = 16'h4004;
   localparam logic [15:0] PLAIN_START_OFS  = 16'h4008;
   localparam logic [15:0] CIPHER_START_OFS = 16'h400c;
   localparam logic [15:0] ENC_KEY_OFS      = 16'h4010;
   localparam int          KEY_SEL_LSB      = 5;
   localparam int          BUSY_BIT         = 7;
   // values after reset
   localparam logic [31:0] WORD_RESET       = 32'h00000000;
   localparam logic [15:0] START_RESET      = 16'h0000;
   localparam logic [6:0]  COUNT_RESET      = 7'h00;
endpackage : aboc_pkg

// file: logic/aboc_op_counter.sv
`timescale 1ns/100ps
module aboc_op_counter #(
   parameter int COUNT_W = 7
) (
   input  wire logic               clk,
   input  wire logic               rst_b,
   input  wire logic               load,
   input  wire logic [COUNT_W-1:0] loadCount,
   input  wire logic               blockDone,
   input  wire logic               engineBusy,
   output logic      [COUNT_W-1:0] remaining,
   output logic                    busy,
   output logic                    start
);
   typedef struct packed {
      logic [COUNT_W-1:0] remaining;
      logic               busy;
      logic               start;
   } aboc_cnt_type;

   aboc_cnt_type state;
   aboc_cnt_type next_state;

   always_comb begin
      next_state       = state;
      next_state.start = 1'b0;
      // a new count is taken only while idle
      if (load && !state.busy) begin
         next_state.remaining = loadCount;
         next_state.start     = (loadCount != '0);
      end else if (blockDone && state.remaining != '0) begin
         next_state.remaining = state.remaining - 1'b1;
      end
      next_state.busy = (next_state.remaining != '0) | engineBusy;
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         state <= '0;
      end else begin
         state <= next_state;
      end
   end

   assign remaining = state.remaining;
   assign busy      = state.busy;
   assign start     = state.start;

   property p_load;
      @(posedge clk) disable iff (!rst_b)
      load && !busy && loadCount != '0 |=> remaining == $past(loadCount) && busy && start;
   endproperty
   a_load: assert property (p_load) else $error("count not taken on command write");

   property p_startPulse;
      @(posedge clk) disable iff (!rst_b)
      start |=> !start;
   endproperty
   a_startPulse: assert property (p_startPulse) else $error("start longer than one cycle");

   property p_dec;
      @(posedge clk) disable iff (!rst_b)
      !(load && !busy) && blockDone && remaining != '0 |=> remaining == $past(remaining) - 1'b1;
   endproperty
   a_dec: assert property (p_dec) else $error("remaining not decremented on block done");

   property p_zeroHold;
      @(posedge clk) disable iff (!rst_b)
      remaining == '0 && !(load && !busy) |=> remaining == '0;
   endproperty
   a_zeroHold: assert property (p_zeroHold) else $error("remaining left zero without a command");

   property p_busyWhileCount;
      @(posedge clk) disable iff (!rst_b)
      remaining != '0 |-> busy;
   endproperty
   a_busyWhileCount: assert property (p_busyWhileCount) else $error("not busy with blocks left");

   property p_idleClears;
      @(posedge clk) disable iff (!rst_b)
      remaining == '0 && !engineBusy && !load ##1 remaining == '0 |-> !busy;
   endproperty
   a_idleClears: assert property (p_idleClears) else $error("busy while idle");
endmodule : aboc_op_counter

// file: logic/aes_block_operation_control.sv
`timescale 1ns/100ps
// Summary of operation
// - A write of a block count to an idle command register starts that many 128-bit blocks; a write while busy is ignored.
// - Bits 6 to 0 of a command register read the blocks still to do and read zero when none remain.
// - Bit 7 of a command register reads one while the engine works and zero when nothing is in progress.
// - Each data memory accepts writes at offsets 0x0000 to 0x07ff above its base.
// - The cipher memory sits 0x2000 above the plain memory base.
// - Writing the lowest encrypt key word pulses the key-valid strobe and the count reads zero once keying ends.
module aes_block_operation_control (
   input  wire logic         clk,
   input  wire logic         rst_b,
   input  wire logic         regWrEn,
   input  wire logic         regRdEn,
   input  wire logic [15:0]  regAddr,
   input  wire logic [31:0]  regWrData,
   output logic      [31:0]  regRdData,
   output logic              regRdValid,
   input  wire logic         encBlockDone,
   input  wire logic         encEngineBusy,
   input  wire logic         decBlockDone,
   input  wire logic         decEngineBusy,
   output logic              encStart,
   output logic              decStart,
   output logic      [6:0]   encBlockQuantity,
   output logic      [6:0]   decBlockQuantity,
   output logic      [15:0]  plainMemoryStartAddress,
   output logic      [15:0]  cipherMemoryStartAddress,
   output logic      [255:0] encryptKey,
   output logic              encryptKeyValidStrobe
);
   typedef struct packed {
      logic [31:0]  rdData;
      logic         rdValid;
      logic [15:0]  plainStart;
      logic [15:0]  cipherStart;
      logic [255:0] key;
      logic         keyValid;
   } aboc_top_type;

   aboc_top_type state;
   aboc_top_type next_state;

   logic [31:0] plainMem  [aboc_pkg::MEM_WORDS];
   logic [31:0] cipherMem [aboc_pkg::MEM_WORDS];

   logic       plainHit;
   logic       cipherHit;
   logic       keyHit;
   logic       keyLowWr;
   logic [15:0] keyOfs;
   logic [31:0] plainAtWord;
   logic       encCmdWr;
   logic       decCmdWr;
   logic [8:0] wordIdx;
   logic [2:0] keyIdx;
   logic [6:0] encRemaining;
   logic [6:0] decRemaining;
   logic       encBusy;
   logic       decBusy;

   // each memory window spans 0x0000..0x07ff above its base
   assign plainHit  = regAddr[15:aboc_pkg::MEM_SEL_LSB] ==
                      aboc_pkg::PLAIN_BASE[15:aboc_pkg::MEM_SEL_LSB];
   assign cipherHit = regAddr[15:aboc_pkg::MEM_SEL_LSB] ==
                      aboc_pkg::CIPHER_BASE[15:aboc_pkg::MEM_SEL_LSB];
   // key words start mid-block, so decode on the offset from the first key word;
   // addresses below it wrap high and miss
   assign keyOfs    = regAddr - aboc_pkg::ENC_KEY_OFS;
   assign keyHit    = keyOfs[15:aboc_pkg::KEY_SEL_LSB] == '0;
   assign wordIdx   = regAddr[aboc_pkg::MEM_SEL_LSB-1:aboc_pkg::WORD_LSB];
   assign keyIdx    = keyOfs[aboc_pkg::KEY_SEL_LSB-1:aboc_pkg::WORD_LSB];
   assign keyLowWr  = regWrEn && keyHit && keyIdx == 3'h0;
   // plain word at the current index, seen by the aliasing check
   assign plainAtWord = plainMem[wordIdx];
   assign encCmdWr  = regWrEn && regAddr == aboc_pkg::ENC_CNT_OFS;
   assign decCmdWr  = regWrEn && regAddr == aboc_pkg::DEC_CNT_OFS;

   always_ff @(posedge clk) begin
      if (regWrEn && plainHit) begin
         plainMem[wordIdx] <= regWrData;
      end
      if (regWrEn && cipherHit) begin
         cipherMem[wordIdx] <= regWrData;
      end
   end

   // engine busy also covers key expansion, so the count reads nonzero during keying
   aboc_op_counter #(
      .COUNT_W (aboc_pkg::COUNT_W)
   ) u_enc_counter (
      .clk        (clk),
      .rst_b      (rst_b),
      .load       (encCmdWr),
      .loadCount  (regWrData[6:0]),
      .blockDone  (encBlockDone),
      .engineBusy (encEngineBusy),
      .remaining  (encRemaining),
      .busy       (encBusy),
      .start      (encStart)
   );

   aboc_op_counter #(
      .COUNT_W (aboc_pkg::COUNT_W)
   ) u_dec_counter (
      .clk        (clk),
      .rst_b      (rst_b),
      .load       (decCmdWr),
      .loadCount  (regWrData[6:0]),
      .blockDone  (decBlockDone),
      .engineBusy (decEngineBusy),
      .remaining  (decRemaining),
      .busy       (decBusy),
      .start      (decStart)
   );

   always_comb begin
      next_state          = state;
      next_state.rdValid  = regRdEn;
      next_state.keyValid = 1'b0;
      next_state.rdData   = aboc_pkg::WORD_RESET;
      if (regWrEn) begin
         if (regAddr == aboc_pkg::PLAIN_START_OFS) begin
            next_state.plainStart = regWrData[15:0];
         end
         if (regAddr == aboc_pkg::CIPHER_START_OFS) begin
            next_state.cipherStart = regWrData[15:0];
         end
         if (keyHit) begin
            next_state.key[keyIdx*32 +: 32] = regWrData;
            next_state.keyValid = (keyIdx == 3'h0);
         end
      end
      if (regRdEn) begin
         if (plainHit) begin
            next_state.rdData = plainMem[wordIdx];
         end else if (cipherHit) begin
            next_state.rdData = cipherMem[wordIdx];
         end else if (keyHit) begin
            next_state.rdData = state.key[keyIdx*32 +: 32];
         end else begin
            case (regAddr)
               aboc_pkg::ENC_CNT_OFS: begin
                  next_state.rdData = {24'h000000, encBusy, encRemaining};
               end
               aboc_pkg::DEC_CNT_OFS: begin
                  next_state.rdData = {24'h000000, decBusy, decRemaining};
               end
               aboc_pkg::PLAIN_START_OFS: begin
                  next_state.rdData = {16'h0000, state.plainStart};
               end
               aboc_pkg::CIPHER_START_OFS: begin
                  next_state.rdData = {16'h0000, state.cipherStart};
               end
               default: begin
                  next_state.rdData = aboc_pkg::WORD_RESET;
               end
            endcase
         end
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         state <= '0;
      end else begin
         state <= next_state;
      end
   end

   assign regRdData                = state.rdData;
   assign regRdValid               = state.rdValid;
   assign plainMemoryStartAddress  = state.plainStart;
   assign cipherMemoryStartAddress = state.cipherStart;
   assign encryptKey               = state.key;
   assign encryptKeyValidStrobe    = state.keyValid;
   assign encBlockQuantity         = encRemaining;
   assign decBlockQuantity         = decRemaining;

   property p_keyStrobe;
      @(posedge clk) disable iff (!rst_b)
      keyLowWr |=> encryptKeyValidStrobe;
   endproperty
   a_keyStrobe: assert property (p_keyStrobe) else $error("key valid missing after low key word");

   property p_keyCause;
      @(posedge clk) disable iff (!rst_b)
      encryptKeyValidStrobe |-> $past(keyLowWr);
   endproperty
   a_keyCause: assert property (p_keyCause) else $error("key valid without low key word write");

   property p_encStatus;
      @(posedge clk) disable iff (!rst_b)
      regRdEn && regAddr == aboc_pkg::ENC_CNT_OFS |=>
         regRdValid && regRdData == {24'h000000, $past(encBusy), $past(encRemaining)};
   endproperty
   a_encStatus: assert property (p_encStatus) else $error("encrypt status read wrong");

   property p_memReadBack;
      @(posedge clk) disable iff (!rst_b)
      (regWrEn && (plainHit || cipherHit)) ##1
         (regRdEn && !regWrEn && regAddr == $past(regAddr)) |=> regRdData == $past(regWrData, 2);
   endproperty
   a_memReadBack: assert property (p_memReadBack) else $error("memory word not kept");

   property p_cipherApart;
      @(posedge clk) disable iff (!rst_b)
      (regWrEn && cipherHit) ##1
         (regRdEn && !regWrEn && regAddr == ($past(regAddr) - aboc_pkg::CIPHER_BASE)) |=>
         regRdData == $past(plainAtWord, 2);
   endproperty
   a_cipherApart: assert property (p_cipherApart) else $error("cipher window aliases plain window");
endmodule : aes_block_operation_control

// file: verif/aboc_engine_model.sv
`timescale 1ns/100ps
// cipher engine stand-in: one done pulse every GAP+1 cycles while blocks remain
module aboc_engine_model #(
   parameter int GAP = 2
) (
   input  wire logic       clk,
   input  wire logic       rst_b,
   input  wire logic       start,
   input  wire logic       keyStrobe,
   input  wire logic [6:0] remaining,
   output logic            blockDone,
   output logic            engineBusy
);
   int tick;
   int tail;
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         tick <= 0;
         tail <= 0;
         blockDone <= 1'b0;
         engineBusy <= 1'b0;
      end else begin
         blockDone <= 1'b0;
         if (start || keyStrobe) begin
            engineBusy <= 1'b1;
            tail <= 4;
            tick <= 0;
         end else if (remaining != 7'h00 && !blockDone) begin
            tick <= (tick + 1 >= GAP) ? 0 : tick + 1;
            blockDone <= (tick + 1 >= GAP);
         end else if (remaining == 7'h00 && tail != 0) begin
            tail <= tail - 1;
         end else if (remaining == 7'h00) begin
            engineBusy <= 1'b0;
         end
      end
   end
endmodule : aboc_engine_model

// file: verif/tb_top.sv
`timescale 1ns/100ps
`define CHK(nm, ex, got) begin totalChecks++; if ((got) !== (ex)) begin badCount++; \
   $display("unexpected %s expected %h seen %h", nm, ex, got); end end
module tb_top;
   typedef struct packed {logic [15:0] addr; logic [31:0] wdata; logic [31:0] rdata;} aboc_row_type;
   logic clk = 1'b0, rst_b = 1'b0, regWrEn = 1'b0, regRdEn = 1'b0;
   logic [15:0] regAddr = 16'h0000;
   logic [31:0] regWrData = 32'h00000000, regRdData, d;
   logic regRdValid, encBlockDone, encEngineBusy, decBlockDone, decEngineBusy, encStart, decStart;
   logic [6:0] encBlockQuantity, decBlockQuantity, cnt;
   logic [15:0] plainMemoryStartAddress, cipherMemoryStartAddress, ofs;
   logic [255:0] encryptKey;
   logic encryptKeyValidStrobe;
   localparam int POLL_MAX = 1000;
   int badCount = 0, totalChecks = 0, cycles = 0, n;
   int dones [2];
   aboc_row_type rows [7] = '{'{16'h0000, 32'ha5a50001, 32'ha5a50001}, '{16'h07fc, 32'h5a5a0002, 32'h5a5a0002},
      '{16'h2000, 32'h11110003, 32'h11110003}, '{16'h27fc, 32'h22220004, 32'h22220004},
      '{16'h0800, 32'h00001234, 32'h00000000}, '{16'h4008, 32'hffff1234, 32'h00001234},
      '{16'h402c, 32'h0badf00d, 32'h0badf00d}};
   always #20 clk = ~clk;
   aes_block_operation_control dut (.clk(clk), .rst_b(rst_b), .regWrEn(regWrEn), .regRdEn(regRdEn),
      .regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData), .regRdValid(regRdValid),
      .encBlockDone(encBlockDone), .encEngineBusy(encEngineBusy), .decBlockDone(decBlockDone),
      .decEngineBusy(decEngineBusy), .encStart(encStart), .decStart(decStart),
      .encBlockQuantity(encBlockQuantity), .decBlockQuantity(decBlockQuantity),
      .plainMemoryStartAddress(plainMemoryStartAddress), .cipherMemoryStartAddress(cipherMemoryStartAddress),
      .encryptKey(encryptKey), .encryptKeyValidStrobe(encryptKeyValidStrobe));
   aboc_engine_model #(.GAP(2)) encEng (.clk(clk), .rst_b(rst_b), .start(encStart),
      .keyStrobe(encryptKeyValidStrobe), .remaining(encBlockQuantity), .blockDone(encBlockDone),
      .engineBusy(encEngineBusy));
   aboc_engine_model #(.GAP(5)) decEng (.clk(clk), .rst_b(rst_b), .start(decStart), .keyStrobe(1'b0),
      .remaining(decBlockQuantity), .blockDone(decBlockDone), .engineBusy(decEngineBusy));
   always @(posedge clk) begin
      dones[0] += encBlockDone;
      dones[1] += decBlockDone;
      cycles++;
      if (cycles == 20000) begin
         badCount++;
         conclude();
      end
   end
   task automatic conclude;
      $display("checks %0d mismatches %0d", totalChecks, badCount);
      if (badCount == 0 && totalChecks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : conclude
   task automatic wr(input logic [15:0] a, input logic [31:0] v);
      @(negedge clk);
      regWrEn = 1'b1;
      regAddr = a;
      regWrData = v;
      @(negedge clk);
      regWrEn = 1'b0;
   endtask : wr
   // write one word, then read another in the very next cycle
   task automatic wr_rd(input logic [15:0] wa, input logic [31:0] wv, input logic [15:0] ra,
                        output logic [31:0] v);
      @(negedge clk);
      regWrEn = 1'b1;
      regAddr = wa;
      regWrData = wv;
      @(negedge clk);
      regWrEn = 1'b0;
      regRdEn = 1'b1;
      regAddr = ra;
      @(negedge clk);
      regRdEn = 1'b0;
      v = regRdData;
   endtask : wr_rd
   task automatic rd(input logic [15:0] a, output logic [31:0] v);
      @(negedge clk);
      regRdEn = 1'b1;
      regAddr = a;
      @(negedge clk);
      regRdEn = 1'b0;
      `CHK("read valid", 1'b1, regRdValid)
      v = regRdData;
   endtask : rd
   task automatic poll(input logic [15:0] a, output int k);
      logic [31:0] v;
      k = 0;
      do begin
         rd(a, v);
         k++;
      end while (v !== 32'h0 && k < POLL_MAX);
   endtask : poll
   initial begin
      repeat (3) @(negedge clk);
      rst_b = 1'b1;
      `CHK("reset quantity", 7'h00, encBlockQuantity)
      `CHK("reset key", 256'h0, encryptKey)
      foreach (rows[i]) begin
         wr(rows[i].addr, rows[i].wdata);
         rd(rows[i].addr, d);
         `CHK("row readback", rows[i].rdata, d)
      end
      wr(16'h0010, 32'h13572468);
      wr_rd(16'h2010, 32'h24681357, 16'h0010, d);
      `CHK("plain kept", 32'h13572468, d)
      wr_rd(16'h07f8, 32'h0000abcd, 16'h07f8, d);
      `CHK("write then read", 32'h0000abcd, d)
      wr(aboc_pkg::ENC_CNT_OFS, 32'h0);
      `CHK("zero count start", 1'b0, encStart)
      for (int ch = 0; ch < 2; ch++) begin
         ofs = ch ? aboc_pkg::DEC_CNT_OFS : aboc_pkg::ENC_CNT_OFS;
         cnt = ch ? 7'h7f : 7'h03;
         wr(aboc_pkg::PLAIN_START_OFS, 32'h10);
         wr(aboc_pkg::CIPHER_START_OFS, 32'h20);
         dones = '{0, 0};
         wr(ofs, {25'h0, cnt});
         `CHK("start", 1'b1, ch ? decStart : encStart)
         `CHK("quantity", cnt, ch ? decBlockQuantity : encBlockQuantity)
         wr(ofs, 32'h5);
         `CHK("restart while busy", 1'b0, ch ? decStart : encStart)
         rd(ofs, d);
         `CHK("busy flag", 1'b1, d[aboc_pkg::BUSY_BIT])
         poll(ofs, n);
         `CHK("finished in time", 1'b1, n < POLL_MAX)
         `CHK("blocks done", cnt, dones[ch][6:0])
         `CHK("cipher start", 16'h0020, cipherMemoryStartAddress)
         `CHK("plain start", 16'h0010, plainMemoryStartAddress)
      end
      wr(aboc_pkg::ENC_KEY_OFS, 32'hcafe0001);
      `CHK("key strobe", 1'b1, encryptKeyValidStrobe)
      `CHK("key word", 32'hcafe0001, encryptKey[31:0])
      // engine busy rises one cycle after the strobe and the flag one after that
      @(negedge clk);
      rd(aboc_pkg::ENC_CNT_OFS, d);
      `CHK("keying busy", 1'b1, d[aboc_pkg::BUSY_BIT])
      poll(aboc_pkg::ENC_CNT_OFS, n);
      `CHK("keying ends", 1'b1, n < POLL_MAX)
      wr(aboc_pkg::ENC_CNT_OFS, 32'h3);
      rst_b = 1'b0;
      @(negedge clk);
      `CHK("reset mid run", 7'h00, encBlockQuantity)
      `CHK("reset start addr", 16'h0000, plainMemoryStartAddress)
      rst_b = 1'b1;
      wr(aboc_pkg::ENC_CNT_OFS, 32'h2);
      `CHK("start after reset", 1'b1, encStart)
      `CHK("quantity after reset", 7'h02, encBlockQuantity)
      @(negedge clk);
      conclude();
   end
endmodule : tb_top
